// ---- flash_id_pkg.sv ----
package flash_id_pkg;

	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_RELEASE_ID  = 8'hAB;
	localparam logic [7:0] OP_MFR_DEV_ID  = 8'h90;
	localparam logic [7:0] OP_STD_IDENT   = 8'h9F;
	localparam logic [7:0] OP_DEEP_PD     = 8'hB9;
	localparam logic [7:0] OP_READ        = 8'h03;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_EN    = 8'h06;
	localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
	localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
	localparam logic [7:0] OP_BULK_ERASE  = 8'hC7;
	localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
	localparam logic [7:0] OP_NONE        = 8'h00;

	// ----------------------------------------
	// Identification and delivered contents
	// ----------------------------------------
	// Identification values are arbitrary
	localparam logic [7:0] MFR_CODE      = 8'h5A;
	localparam logic [7:0] DEVICE_CODE   = 8'h12;
	localparam logic [7:0] MEM_TYPE      = 8'h20;
	localparam logic [7:0] MEM_CAPACITY  = 8'h13;
	localparam logic [7:0] ERASED_BYTE   = 8'hFF;
	localparam logic [7:0] STATUS_RESET  = 8'h00;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam logic [5:0] OPCODE_LAST   = 6'h07;
	localparam logic [5:0] HEADER_LAST   = 6'h1F;
	localparam logic [5:0] HEADER_BITS   = 6'h20;
	localparam logic [4:0] LEN_BYTE      = 5'h08;
	localparam logic [4:0] LEN_PAIR      = 5'h10;
	localparam logic [4:0] LEN_TRIPLE    = 5'h18;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ                = 100;
	localparam int RELEASE_DELAY_NS       = 3000;
	localparam int SIG_RELEASE_DELAY_NS   = 1800;
	localparam int DPD_ENTRY_NS           = 3000;
	localparam int SELECT_HIGH_NS         = 100;
	localparam int WRITE_INHIBIT_MIN_MS   = 1;
	localparam int WRITE_INHIBIT_MAX_MS   = 10;
	// Device side finishes within a longest time: round down
	localparam int DEV_RELEASE_CYC        = RELEASE_DELAY_NS * CLK_MHZ / 1000;
	localparam int DEV_SIG_RELEASE_CYC    = SIG_RELEASE_DELAY_NS * CLK_MHZ / 1000;
	localparam int DEV_DPD_ENTRY_CYC      = DPD_ENTRY_NS * CLK_MHZ / 1000;
	localparam int DEV_WRITE_INHIBIT_CYC  = WRITE_INHIBIT_MIN_MS * CLK_MHZ * 1000;
	// Host side waits a least time: round up
	localparam int HOST_RELEASE_CYC       = (RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_SIG_RELEASE_CYC   = (SIG_RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_DPD_ENTRY_CYC     = (DPD_ENTRY_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_SELECT_HIGH_CYC   = (SELECT_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_WRITE_INHIBIT_CYC = WRITE_INHIBIT_MAX_MS * CLK_MHZ * 1000;
	localparam logic [2:0] SCK_PHASE_RISE = 3'h4;
	localparam logic [2:0] SCK_PHASE_LAST = 3'h7;

	typedef enum logic [3:0] {
		PS_STANDBY   = 4'b0001,
		PS_DPD_ENTRY = 4'b0010,
		PS_DPD       = 4'b0100,
		PS_RELEASE   = 4'b1000
	} power_state_t;

	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_HOLD = 4'b0010,
		HS_XFER = 4'b0100,
		HS_GAP  = 4'b1000
	} host_state_t;

endpackage

// ---- flash_link_if.sv ----
`timescale 1ns/1ps
interface flash_link_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;

	modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
	modport host (output cs_n, output sck, output mosi, input miso);
endinterface

// ---- flash_id_device.sv ----
`timescale 1ns/1ps
// Functional notes
// - In deep power-down only release opcode accepted
// - Release-only frame resumes after release delay
// - Host keeps select high during release delay
// - After opcode and dummies, device ID MSB-first
// - Device ID repeats until select rises
// - Standby at once, or after signature delay
// - Device ID readable without prior power-down
// - Release opcode ignored during write cycles
// - Opcode 90h, address zero: maker then device
// - Address one swaps: device then maker code
// - Opcode 9Fh gives maker, type, capacity
// - Opcode 9Fh ignored during program or erase
// - Host avoids 9Fh during deep power-down
// - Select rise ends 9Fh output, then standby
// - Write opcodes refused during power-up delay
// - Delivered array reads all FFh
// - Delivered status register reads 00h
// - Release delays 3 us and 1.8 us
// - Power-down entry by B9h within 3 us
module flash_id_device
	import flash_id_pkg::*;
#(
	parameter int WRITE_INHIBIT_CYC = DEV_WRITE_INHIBIT_CYC
)
(
	input  logic         clock,
	input  logic         rst_n,
	flash_link_if.device link,
	input  logic         prog_erase_busy,
	input  logic         status_write_busy,
	output logic         deep_power_down,
	output logic         standby,
	output logic         write_inhibit
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	power_state_t state;
	logic [8:0]   timer;
	logic         dpd_level;
	logic [19:0]  inhibit_cnt;
	logic [1:0]   cs_sync;
	logic         cs_high_d;
	logic [1:0]   tgl_sync;
	logic         tgl_seen;
	logic         cs_rise;
	logic         new_cmd;

	logic [1:0]   dpd_sync;
	logic [1:0]   pe_sync;
	logic [1:0]   sw_sync;
	logic [1:0]   wi_sync;
	logic [5:0]   bit_cnt;
	logic [6:0]   shift_in;
	logic [7:0]   op;
	logic         op_ok;
	logic [7:0]   next_byte;
	logic         next_ok;
	logic         tx_go;
	logic [23:0]  tx_word;
	logic [4:0]   tx_len;
	logic [4:0]   pos;
	logic [7:0]   frame_cmd;
	logic         frame_tgl;
	logic         sig_read;

	// ----------------------------------------
	// Link side: synchronisers
	// ----------------------------------------
	always_ff @(posedge link.sck)
	begin
		dpd_sync <= {dpd_sync[0], dpd_level};
		pe_sync  <= {pe_sync[0], prog_erase_busy};
		sw_sync  <= {sw_sync[0], status_write_busy};
		wi_sync  <= {wi_sync[0], write_inhibit};
	end

	// ----------------------------------------
	// Link side: opcode filter
	// ----------------------------------------
	assign next_byte = {shift_in, link.mosi};

	always_comb
	begin
		next_ok = 1'b1;
		if (dpd_sync[1])
			next_ok = (next_byte == OP_RELEASE_ID);
		else if (next_byte == OP_RELEASE_ID)
			next_ok = !(pe_sync[1] || sw_sync[1]);
		else if (next_byte == OP_STD_IDENT)
			next_ok = !pe_sync[1];
		else if (next_byte == OP_READ || next_byte == OP_MFR_DEV_ID)
			next_ok = !(pe_sync[1] || sw_sync[1]);
		else if (next_byte == OP_WRITE_EN || next_byte == OP_PAGE_PROG || next_byte == OP_SECT_ERASE
			|| next_byte == OP_BULK_ERASE || next_byte == OP_WRITE_STAT)
			next_ok = !wi_sync[1];
	end

	// ----------------------------------------
	// Link side: input framing and response select
	// ----------------------------------------
	always_ff @(posedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			bit_cnt  <= 6'h00;
			shift_in <= 7'h00;
			op       <= OP_NONE;
			op_ok    <= 1'b0;
			tx_go    <= 1'b0;
			tx_word  <= 24'h00_0000;
			tx_len   <= LEN_BYTE;
		end
		else
		begin
			// Bits taken on the rising edge
			shift_in <= next_byte[6:0];
			if (bit_cnt != HEADER_BITS)
				bit_cnt <= bit_cnt + 6'h01;
			if (bit_cnt == OPCODE_LAST)
			begin
				op    <= next_byte;
				op_ok <= next_ok;
				if (next_ok && next_byte == OP_STD_IDENT)
				begin
					tx_go   <= 1'b1;
					tx_word <= {MFR_CODE, MEM_TYPE, MEM_CAPACITY};
					tx_len  <= LEN_TRIPLE;
				end
				if (next_ok && next_byte == OP_READ_STATUS)
				begin
					tx_go   <= 1'b1;
					tx_word <= {STATUS_RESET[7:1], pe_sync[1] | sw_sync[1], 16'h0000};
					tx_len  <= LEN_BYTE;
				end
			end
			if (bit_cnt == HEADER_LAST && op_ok)
			begin
				unique case (op)
					OP_RELEASE_ID:
					begin
						tx_go   <= 1'b1;
						tx_word <= {DEVICE_CODE, 16'h0000};
						tx_len  <= LEN_BYTE;
					end
					OP_MFR_DEV_ID:
					begin
						tx_go  <= 1'b1;
						tx_len <= LEN_PAIR;
						if (next_byte[0])
							tx_word <= {DEVICE_CODE, MFR_CODE, 8'h00};
						else
							tx_word <= {MFR_CODE, DEVICE_CODE, 8'h00};
					end
					OP_READ:
					begin
						tx_go   <= 1'b1;
						tx_word <= {ERASED_BYTE, 16'h0000};
						tx_len  <= LEN_BYTE;
					end
					default:
					begin
						// Responses started at the opcode keep running
						tx_go <= tx_go;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Link side: output shifter
	// ----------------------------------------
	always_ff @(negedge link.sck or posedge link.cs_n)
	begin
		if (link.cs_n)
		begin
			link.miso_oe <= 1'b0;
			link.miso    <= 1'b0;
			pos          <= 5'h00;
		end
		else if (tx_go)
		begin
			link.miso_oe <= 1'b1;
			link.miso    <= tx_word[5'd23 - pos];
			if (pos == tx_len - 5'h01)
				pos <= 5'h00;
			else
				pos <= pos + 5'h01;
		end
	end

	// ----------------------------------------
	// Link side: executed opcode handed to the core
	// ----------------------------------------
	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_cmd <= OP_NONE;
			frame_tgl <= 1'b0;
			sig_read  <= 1'b0;
		end
		else if (bit_cnt == OPCODE_LAST && next_ok)
		begin
			frame_cmd <= next_byte;
			frame_tgl <= ~frame_tgl;
			sig_read  <= 1'b0;
		end
		else if (bit_cnt == OPCODE_LAST + 6'h01)
		begin
			sig_read <= 1'b1;
			// A power-down opcode with trailing bits is not executed
			if (frame_cmd == OP_DEEP_PD)
				frame_cmd <= OP_NONE;
		end
	end

	// ----------------------------------------
	// Core side: select and handoff synchronisers
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cs_sync   <= 2'b11;
			cs_high_d <= 1'b1;
			tgl_sync  <= 2'b00;
		end
		else
		begin
			cs_sync   <= {cs_sync[0], link.cs_n};
			cs_high_d <= cs_sync[1];
			tgl_sync  <= {tgl_sync[0], frame_tgl};
		end
	end

	assign cs_rise = cs_sync[1] && !cs_high_d;
	assign new_cmd = tgl_sync[1] != tgl_seen;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tgl_seen <= 1'b0;
		else if (cs_rise && new_cmd)
			tgl_seen <= tgl_sync[1];
	end

	// ----------------------------------------
	// Core side: power state
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= PS_STANDBY;
			timer <= 9'h000;
		end
		else
		begin
			unique case (state)
				PS_STANDBY:
				begin
					if (cs_rise && new_cmd && frame_cmd == OP_DEEP_PD)
					begin
						state <= PS_DPD_ENTRY;
						timer <= 9'(DEV_DPD_ENTRY_CYC - 1);
					end
				end
				PS_DPD_ENTRY, PS_DPD:
				begin
					if (cs_rise && new_cmd && frame_cmd == OP_RELEASE_ID)
					begin
						state <= PS_RELEASE;
						if (sig_read)
							timer <= 9'(DEV_SIG_RELEASE_CYC - 1);
						else
							timer <= 9'(DEV_RELEASE_CYC - 1);
					end
					else if (state == PS_DPD_ENTRY)
					begin
						if (timer == 9'h000)
							state <= PS_DPD;
						else
							timer <= timer - 9'h001;
					end
				end
				PS_RELEASE:
				begin
					if (timer == 9'h000)
						state <= PS_STANDBY;
					else
						timer <= timer - 9'h001;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			dpd_level       <= 1'b0;
			deep_power_down <= 1'b0;
			standby         <= 1'b1;
		end
		else
		begin
			dpd_level       <= state != PS_STANDBY;
			deep_power_down <= state == PS_DPD;
			standby         <= state == PS_STANDBY && cs_sync[1];
		end
	end

	// ----------------------------------------
	// Core side: write inhibit after power-up
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			inhibit_cnt   <= 20'h0_0000;
			write_inhibit <= 1'b1;
		end
		else if (write_inhibit)
		begin
			inhibit_cnt <= inhibit_cnt + 20'h0_0001;
			if (inhibit_cnt == 20'(WRITE_INHIBIT_CYC - 1))
				write_inhibit <= 1'b0;
		end
	end

endmodule

// ---- flash_id_host.sv ----
`timescale 1ns/1ps
module flash_id_host
	import flash_id_pkg::*;
#(
	parameter int WRITE_WAIT_CYC = HOST_WRITE_INHIBIT_CYC
)
(
	input  logic       clock,
	input  logic       rst_n,
	flash_link_if.host link,
	input  logic       cmd_valid,
	input  logic [7:0] cmd_op,
	input  logic [23:0] cmd_addr,
	input  logic       cmd_has_addr,
	input  logic [3:0] cmd_rd_bytes,
	output logic       cmd_ready,
	output logic       rsp_valid,
	output logic [7:0] rsp_data,
	output logic       in_dpd
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	host_state_t state;
	logic [31:0] sh_out;
	logic [7:0]  n_out;
	logic [7:0]  n_tot;
	logic [7:0]  bit_idx;
	logic [2:0]  phase;
	logic [8:0]  gap;
	logic [7:0]  cur_op;
	logic [6:0]  rx;
	logic [1:0]  miso_sync;
	logic [19:0] wi_cnt;
	logic        wi_active;
	logic        is_write;

	assign is_write = cur_op == OP_WRITE_EN || cur_op == OP_PAGE_PROG || cur_op == OP_SECT_ERASE
		|| cur_op == OP_BULK_ERASE || cur_op == OP_WRITE_STAT;

	always_ff @(posedge clock)
	begin
		miso_sync <= {miso_sync[0], link.miso};
	end

	// ----------------------------------------
	// Write wait after power-up
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wi_cnt    <= 20'h0_0000;
			wi_active <= 1'b1;
		end
		else if (wi_active)
		begin
			wi_cnt <= wi_cnt + 20'h0_0001;
			if (wi_cnt == 20'(WRITE_WAIT_CYC - 1))
				wi_active <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state     <= HS_IDLE;
			cmd_ready <= 1'b1;
			link.cs_n <= 1'b1;
			link.sck  <= 1'b0;
			link.mosi <= 1'b0;
			sh_out    <= 32'h0000_0000;
			n_out     <= 8'h00;
			n_tot     <= 8'h00;
			bit_idx   <= 8'h00;
			phase     <= 3'h0;
			gap       <= 9'h000;
			cur_op    <= OP_NONE;
			rx        <= 7'h00;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			in_dpd    <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			unique case (state)
				HS_IDLE:
				begin
					if (cmd_valid && cmd_ready)
					begin
						cmd_ready <= 1'b0;
						cur_op    <= cmd_op;
						sh_out    <= {cmd_op, cmd_addr};
						n_out     <= cmd_has_addr ? 8'h20 : 8'h08;
						n_tot     <= (cmd_has_addr ? 8'h20 : 8'h08) + {1'b0, cmd_rd_bytes, 3'h0};
						bit_idx   <= 8'h00;
						phase     <= 3'h0;
						if (cmd_op == OP_STD_IDENT && in_dpd)
							cmd_ready <= 1'b1;
						else
							state <= HS_HOLD;
					end
				end
				HS_HOLD:
				begin
					if (!(is_write && wi_active))
					begin
						state     <= HS_XFER;
						link.cs_n <= 1'b0;
					end
				end
				HS_XFER:
				begin
					phase <= phase + 3'h1;
					if (phase == 3'h0)
					begin
						link.sck  <= 1'b0;
						link.mosi <= sh_out[31];
					end
					if (phase == SCK_PHASE_RISE)
					begin
						link.sck <= 1'b1;
						if (bit_idx >= n_out)
						begin
							rx <= {rx[5:0], miso_sync[1]};
							if (bit_idx[2:0] == 3'h7)
							begin
								rsp_valid <= 1'b1;
								rsp_data  <= {rx, miso_sync[1]};
							end
						end
					end
					if (phase == SCK_PHASE_LAST)
					begin
						sh_out  <= {sh_out[30:0], 1'b0};
						bit_idx <= bit_idx + 8'h01;
						if (bit_idx == n_tot - 8'h01)
						begin
							// Early end of an identification read is allowed
							state <= HS_GAP;
							gap   <= 9'(HOST_SELECT_HIGH_CYC);
							if (cur_op == OP_DEEP_PD)
							begin
								gap    <= 9'(HOST_DPD_ENTRY_CYC);
								in_dpd <= 1'b1;
							end
							if (cur_op == OP_RELEASE_ID && in_dpd)
							begin
								in_dpd <= 1'b0;
								if (n_tot == n_out)
									gap <= 9'(HOST_RELEASE_CYC);
								else
									gap <= 9'(HOST_SIG_RELEASE_CYC);
							end
						end
					end
				end
				HS_GAP:
				begin
					link.sck <= 1'b0;
					if (!link.sck)
						link.cs_n <= 1'b1;
					if (link.cs_n)
					begin
						if (gap == 9'h000)
						begin
							state     <= HS_IDLE;
							cmd_ready <= 1'b1;
						end
						else
							gap <= gap - 9'h001;
					end
				end
			endcase
		end
	end

endmodule

// ---- flash_id_properties.sv ----
`timescale 1ns/1ps
module flash_id_properties
	import flash_id_pkg::*;
(
	input logic clock,
	input logic rst_n,
	input logic cs_n,
	input logic sck,
	input logic mosi,
	input logic miso,
	input logic miso_oe
);
	logic [7:0] op;
	logic [5:0] bits;
	logic [9:0] gap;
	logic       dpd;
	int         need;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n || cs_n)
			bits <= 6'h00;
		else if ($rose(sck) && bits != 6'h3F)
			bits <= bits + 6'h01;
	end

	always_ff @(posedge clock)
	begin
		if (!cs_n && $rose(sck) && bits < 6'h08)
			op <= {op[6:0], mosi};
	end

	// Power-down as the frames on the wire imply it
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			dpd <= 1'h0;
		else if ($rose(cs_n) && bits == 6'h08 && op == OP_DEEP_PD)
			dpd <= 1'h1;
		else if ($rose(cs_n) && op == OP_RELEASE_ID)
			dpd <= 1'h0;
	end

	// Least deselect time owed before the next frame
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			need <= 0;
		else if ($rose(cs_n) && dpd && op == OP_RELEASE_ID)
			need <= (bits == 6'h08) ? HOST_RELEASE_CYC : HOST_SIG_RELEASE_CYC;
		else if ($rose(cs_n))
			need <= HOST_SELECT_HIGH_CYC;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n || !cs_n)
			gap <= 10'h000;
		else if (gap != 10'h3FF)
			gap <= gap + 10'h001;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_deselect_quiet: assert property (cs_n |-> !miso_oe) else $error("output on while deselected");
	a_sck_idle_low: assert property (cs_n |-> !sck) else $error("link clock high while deselected");
	a_mosi_held: assert property (!cs_n && sck |-> $stable(mosi)) else $error("input moved while clock high");
	a_sck_high_four: assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("clock high time wrong");
	a_miso_on_low: assert property (miso_oe && $changed(miso) |-> !sck) else $error("output moved while high");
	a_output_start: assert property ($rose(miso_oe) |->
		(bits == 6'h08 && (op == OP_STD_IDENT || op == OP_READ_STATUS)) ||
		(bits == 6'h20 && (op == OP_RELEASE_ID || op == OP_MFR_DEV_ID || op == OP_READ)))
		else $error("output began at the wrong bit");
	a_dpd_discard: assert property ($rose(miso_oe) |-> !dpd || op == OP_RELEASE_ID)
		else $error("answer given in power-down");
	a_reselect_gap: assert property ($fell(cs_n) |-> int'(gap) >= need)
		else $error("reselected too early");

	c_ident_out: cover property ($rose(miso_oe) && op == OP_STD_IDENT);
	c_release_read: cover property ($rose(miso_oe) && dpd);
	c_release_only: cover property ($fell(cs_n) && need == HOST_RELEASE_CYC);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import flash_id_pkg::*;
();
	localparam int INHIBIT_CYC = 50;
	localparam int WRITE_WAIT  = 100;

	logic        clock, rst_n, cmd_valid, cmd_has_addr, cmd_ready, rsp_valid, in_dpd;
	logic        prog_erase_busy, status_write_busy, deep_power_down, standby, write_inhibit;
	logic        oe_seen, quiet;
	logic [3:0]  cmd_rd_bytes;
	logic [7:0]  cmd_op, rsp_data;
	logic [23:0] cmd_addr;
	logic [31:0] seed;
	logic [7:0]  exp_q [$];
	logic [7:0]  op_tab [5] = '{OP_STD_IDENT, OP_MFR_DEV_ID, OP_RELEASE_ID, OP_READ, OP_READ_STATUS};
	int          failures = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          first_sel = 0;

	flash_link_if link ();

	flash_id_device #(.WRITE_INHIBIT_CYC(INHIBIT_CYC)) flash_id_device_inst (.clock(clock), .rst_n(rst_n),
		.link(link.device), .prog_erase_busy(prog_erase_busy), .status_write_busy(status_write_busy),
		.deep_power_down(deep_power_down), .standby(standby), .write_inhibit(write_inhibit));

	flash_id_host #(.WRITE_WAIT_CYC(WRITE_WAIT)) flash_id_host_inst (.clock(clock), .rst_n(rst_n), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_has_addr(cmd_has_addr),
		.cmd_rd_bytes(cmd_rd_bytes), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.in_dpd(in_dpd));

	flash_id_properties flash_id_properties_inst (.clock(clock), .rst_n(rst_n), .cs_n(link.cs_n),
		.sck(link.sck), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

	initial
	begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] expect_at(input logic [7:0] op, input logic swap, input int k);
		case (op)
			OP_STD_IDENT:  return (k % 3 == 0) ? MFR_CODE : ((k % 3 == 1) ? MEM_TYPE : MEM_CAPACITY);
			OP_MFR_DEV_ID: return ((k % 2 == 0) ^ swap) ? MFR_CODE : DEVICE_CODE;
			OP_RELEASE_ID: return DEVICE_CODE;
			OP_READ:       return ERASED_BYTE;
			default:       return STATUS_RESET;
		endcase
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want)
		begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_ready();
		for (int k = 0; k < 2000 && cmd_ready !== 1'h1; k++)
			@(posedge clock) #1;
		if (cmd_ready !== 1'h1)
		begin
			failures++;
			$display("unexpected at %0t: host never ready", $time);
		end
	endtask

	task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic has_addr, input logic [3:0] n);
		wait_ready();
		cmd_valid = 1'h1;
		cmd_op = op;
		cmd_addr = addr;
		cmd_has_addr = has_addr;
		cmd_rd_bytes = n;
		@(posedge clock) #1;
		cmd_valid = 1'h0;
		wait_ready();
	endtask

	task automatic read_id(input logic [7:0] op, input logic [23:0] addr, input int n);
		for (int k = 0; k < n; k++)
			exp_q.push_back(expect_at(op, addr[0], k));
		send(op, addr, op != OP_STD_IDENT && op != OP_READ_STATUS, 4'(n));
	endtask

	// Waits for power-down to be entered or left, standby being its opposite
	task automatic settle(input logic want);
		for (int k = 0; k < 400 && (deep_power_down !== want || standby === want); k++)
			@(posedge clock) #1;
		check({7'h00, deep_power_down}, {7'h00, want});
		check({7'h00, standby}, {7'h00, ~want});
	endtask

	always @(posedge clock)
	begin
		if (rst_n === 1'h1)
			cyc++;
		if (link.cs_n === 1'h0 && first_sel == 0)
			first_sel = cyc;
		if (link.miso_oe === 1'h1)
			oe_seen = 1'h1;
		if (rsp_valid === 1'h1 && quiet !== 1'h1)
		begin
			if (exp_q.size() > 0)
				check(rsp_data, exp_q.pop_front());
			else
			begin
				failures++;
				$display("unexpected at %0t: response with none pending", $time);
			end
		end
	end

	initial
	begin
		#400_000;
		failures++;
		$display("unexpected at %0t: run timed out", $time);
		end_sim();
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r;
		cmd_valid = 1'h0;
		cmd_op = 8'h00;
		cmd_addr = 24'h00_0000;
		cmd_has_addr = 1'h0;
		cmd_rd_bytes = 4'h0;
		prog_erase_busy = 1'h0;
		status_write_busy = 1'h0;
		oe_seen = 1'h0;
		quiet = 1'h0;
		seed = 32'h0000_FE72;
		rst_n = 1'h0;
		repeat (6) @(posedge clock);
		#1;
		rst_n = 1'h1;
		check({7'h00, write_inhibit}, 8'h01);
		check({7'h00, standby}, 8'h01);
		repeat (INHIBIT_CYC + 2) @(posedge clock);
		#1;
		check({7'h00, write_inhibit}, 8'h00);
		// A write opcode waits in the host until its write wait ends
		send(OP_WRITE_EN, 24'h00_0000, 1'h0, 4'h0);
		check({7'h00, first_sel >= WRITE_WAIT}, 8'h01);
		// Every identification read, random lengths end some mid-pattern
		for (int i = 0; i < 10; i++)
		begin
			r = xorshift();
			read_id(op_tab[i % 5], (i % 5 == 1) ? {23'h00_0000, i[0]} : r[23:0], 4 + int'(r[31:30]) % 3);
		end
		// Reads refused while a write cycle runs, but 9Fh answered in a status write
		quiet = 1'h1;
		oe_seen = 1'h0;
		prog_erase_busy = 1'h1;
		send(OP_STD_IDENT, 24'h00_0000, 1'h0, 4'h1);
		send(OP_RELEASE_ID, r[23:0], 1'h1, 4'h1);
		prog_erase_busy = 1'h0;
		status_write_busy = 1'h1;
		send(OP_RELEASE_ID, r[23:0], 1'h1, 4'h1);
		check({7'h00, oe_seen}, 8'h00);
		quiet = 1'h0;
		read_id(OP_STD_IDENT, 24'h00_0000, 3);
		status_write_busy = 1'h0;
		// Power-down, discarded frames, release with and without a read
		send(OP_DEEP_PD, 24'h00_0000, 1'h0, 4'h0);
		check({7'h00, in_dpd}, 8'h01);
		settle(1'h1);
		quiet = 1'h1;
		oe_seen = 1'h0;
		send(OP_MFR_DEV_ID, 24'h00_0000, 1'h1, 4'h1);
		send(OP_READ_STATUS, 24'h00_0000, 1'h0, 4'h1);
		send(OP_STD_IDENT, 24'h00_0000, 1'h0, 4'h1);
		quiet = 1'h0;
		check({7'h00, oe_seen}, 8'h00);
		check({7'h00, deep_power_down}, 8'h01);
		read_id(OP_RELEASE_ID, r[23:0], 2);
		check({7'h00, in_dpd}, 8'h00);
		settle(1'h0);
		send(OP_DEEP_PD, 24'h00_0000, 1'h0, 4'h0);
		settle(1'h1);
		send(OP_RELEASE_ID, 24'h00_0000, 1'h0, 4'h0);
		settle(1'h0);
		read_id(OP_MFR_DEV_ID, 24'h00_0001, 3);
		check(8'(exp_q.size()), 8'h00);
		end_sim();
	end
endmodule
